// >>> hw/lbmd_defs.vh
`ifndef LBMD_DEFS_VH
`define LBMD_DEFS_VH

// Transfer type codes.
`define LBMD_TT_NORMAL_MAX   2'h2
`define LBMD_TT_IACK         2'h3

// Region bounds, inclusive.
`define LBMD_BOOT_LO         32'hFF80_0000
`define LBMD_BOOT_HI         32'hFFBF_FFFF
`define LBMD_BOOT_HALF_BIT   21
`define LBMD_ALIAS_HI        32'h003F_FFFF
`define LBMD_SRAM_LO         32'hFFE0_0000
`define LBMD_SRAM_HI         32'hFFEF_FFFF
`define LBMD_IO_LO           32'hFFF0_0000
`define LBMD_IO_HI           32'hFFFE_FFFF
`define LBMD_A16_LO          32'hFFFF_0000

// Local I/O registers of interest.
`define LBMD_BRIDGE_LO       32'hFFF4_0000
`define LBMD_BRIDGE_HI       32'hFFF4_01FF
`define LBMD_COMP_LO         32'hFFF4_2000
`define LBMD_COMP_HI         32'hFFF4_2FFF
`define LBMD_ADDR_BRG_GPI    32'hFFF4_0088
`define LBMD_ADDR_BRG_PRESC  32'hFFF4_0064
`define LBMD_ADDR_COMP_GPI   32'hFFF4_202C
`define LBMD_ADDR_COMP_ABORT 32'hFFF4_2043
`define LBMD_ADDR_COMP_RST   32'hFFF4_2044
`define LBMD_ADDR_COMP_PRESC 32'hFFF4_204C
`define LBMD_GPI_LSB         16
`define LBMD_ABORT_LSB       0

// Bus timer choices, in microseconds, and the clock rate in MHz.
`define LBMD_TMO_8US         8
`define LBMD_TMO_64US        64
`define LBMD_TMO_256US       256
`define LBMD_CLK_MHZ         200

`endif

// >>> hw/lbmd_bus_timer.v
`timescale 1ns/1ps
module lbmd_bus_timer #(
  parameter CW = 16
) (
  input  wire          clk,
  input  wire          arst_n,
  input  wire          run,
  input  wire [CW-1:0] limit,
  output reg           expired_r
);
  reg [CW-1:0] count_r;

  always @(posedge clk or negedge arst_n) begin
    if (!arst_n) begin
      count_r   <= {CW{1'b0}};
      expired_r <= 1'b0;
    end else if (!run) begin
      count_r   <= {CW{1'b0}};
      expired_r <= 1'b0;
    end else begin
      count_r   <= count_r + {{(CW-1){1'b0}}, 1'b1};
      expired_r <= (count_r == limit);
    end
  end
endmodule // lbmd_bus_timer

// >>> hw/lbmd_decoder.v
`timescale 1ns/1ps
`include "lbmd_defs.vh"
module lbmd_decoder #(
  parameter [31:0] MAIN_MEMORY_EXTENT = 32'h0400_0000,
  parameter [31:0] XLATE_BASE         = 32'h0000_0000
) (
  input  wire        clk,
  input  wire        arst_n,
  input  wire        cycle_start,
  input  wire [31:0] addr,
  input  wire [1:0]  transfer_type_code,
  input  wire        cycle_end,
  input  wire        sys_bus_enable,
  input  wire        bridge_present,
  input  wire        bridge_boot_decode_en,
  input  wire        bus_timer_enable,
  input  wire [1:0]  bus_timer_sel,
  input  wire        clear_boot_alias,
  input  wire        flash_wp_ctl,
  input  wire        flash_half_ctl,
  input  wire        boot_config_ctl,
  input  wire        supply_status_input,
  input  wire [7:0]  general_input_pins,
  input  wire        abort_switch,
  input  wire        abort_int_enable,
  input  wire [31:0] reset_wdog_bits,
  input  wire        sys_in_valid,
  input  wire [31:0] sys_in_addr,
  output reg         flash_write_protect_out,
  output reg         flash_half_select_out,
  output reg         boot_config_select_out,
  output reg         supply_status_r,
  output reg         boot_alias_bit,
  output reg         sel_main_mem_r,
  output reg         sel_sys_bus_r,
  output reg         sel_boot_r,
  output reg         sel_sram_r,
  output reg         sel_local_io_r,
  output reg         sel_iack_r,
  output reg         sel_bridge_prescaler_r,
  output reg         dup_logic_enable_r,
  output reg         abort_irq_r,
  output reg  [31:0] comp_read_data_r,
  output reg         ack_none_r,
  output reg         transfer_error_r,
  output reg         sys_in_valid_r,
  output reg  [31:0] sys_in_local_addr_r,
  output reg  [21:0] boot_dev_addr_r
);
  localparam [1:0] ST_IDLE = 2'h0;
  localparam [1:0] ST_WAIT = 2'h1;
  localparam [1:0] ST_TERM = 2'h2;
  localparam integer TMO8   = `LBMD_TMO_8US * `LBMD_CLK_MHZ;
  localparam integer TMO64  = `LBMD_TMO_64US * `LBMD_CLK_MHZ;
  localparam integer TMO256 = `LBMD_TMO_256US * `LBMD_CLK_MHZ;

  reg  [1:0]  state_r;
  reg  [1:0]  state_nxt;
  reg         undecoded_r;
  reg  [15:0] tmo_limit;
  reg         hit_main;
  reg         hit_sys;
  reg         hit_boot;
  reg         hit_sram;
  reg         hit_io;
  reg         hit_undec;
  reg  [31:0] rd_nxt;
  wire        expired;
  wire        normal_type;
  wire        iack_type;
  wire        in_io;

  assign normal_type = (transfer_type_code <= `LBMD_TT_NORMAL_MAX);
  assign iack_type   = (transfer_type_code == `LBMD_TT_IACK);
  assign in_io       = (addr >= `LBMD_IO_LO) && (addr <= `LBMD_IO_HI);

  // Priority order keeps regions exclusive even while the alias overlaps
  // main memory near address zero.
  always @* begin
    hit_main  = 1'b0;
    hit_sys   = 1'b0;
    hit_boot  = 1'b0;
    hit_sram  = 1'b0;
    hit_io    = 1'b0;
    hit_undec = 1'b0;
    if (normal_type) begin
      if (boot_alias_bit && addr <= `LBMD_ALIAS_HI)
        hit_boot = 1'b1;
      else if (addr < MAIN_MEMORY_EXTENT)
        hit_main = 1'b1;
      else if (addr < `LBMD_BOOT_LO)
        hit_sys = 1'b1;
      else if (addr <= `LBMD_BOOT_HI)
        hit_boot = 1'b1;
      else if (addr >= `LBMD_SRAM_LO && addr <= `LBMD_SRAM_HI)
        hit_sram = 1'b1;
      else if (in_io)
        hit_io = 1'b1;
      else if (addr >= `LBMD_A16_LO)
        hit_sys = 1'b1;
      else
        hit_undec = 1'b1;
    end
  end

  always @* begin
    case (bus_timer_sel)
      2'h0:    tmo_limit = TMO8[15:0];
      2'h1:    tmo_limit = TMO64[15:0];
      2'h2:    tmo_limit = TMO256[15:0];
      default: tmo_limit = 16'hFFFF;
    endcase
  end

  // The infinite setting simply never runs the timer.
  lbmd_bus_timer #(
    .CW (16)
  ) u_timer (
    .clk       (clk),
    .arst_n    (arst_n),
    .run       (state_r == ST_WAIT && undecoded_r && bus_timer_enable &&
                bus_timer_sel != 2'h3),
    .limit     (tmo_limit),
    .expired_r (expired)
  );

  always @* begin
    state_nxt = state_r;
    case (state_r)
      ST_IDLE: begin
        if (cycle_start)
          state_nxt = ST_WAIT;
      end
      ST_WAIT: begin
        if (expired)
          state_nxt = ST_TERM;
        else if (cycle_end)
          state_nxt = ST_IDLE;
      end
      ST_TERM: state_nxt = ST_IDLE;
      default: state_nxt = ST_IDLE;
    endcase
  end

  always @* begin
    rd_nxt = 32'h0000_0000;
    if (addr == `LBMD_ADDR_COMP_GPI)
      rd_nxt[`LBMD_GPI_LSB +: 8] = general_input_pins;
    // Abort control; any byte of its word selects it.
    else if ({addr[31:2], 2'h3} == `LBMD_ADDR_COMP_ABORT)
      rd_nxt[`LBMD_ABORT_LSB +: 2] = {abort_int_enable, abort_switch};
    else if (addr == `LBMD_ADDR_COMP_RST)
      rd_nxt = reset_wdog_bits;
    else if (addr == `LBMD_ADDR_BRG_GPI)
      rd_nxt = 32'h0000_0000;
  end

  always @(posedge clk or negedge arst_n) begin
    if (!arst_n) begin
      state_r                 <= ST_IDLE;
      undecoded_r             <= 1'b0;
      flash_write_protect_out <= 1'b0;
      flash_half_select_out   <= 1'b0;
      boot_config_select_out  <= 1'b0;
      supply_status_r         <= 1'b0;
      boot_alias_bit          <= 1'b1;
      sel_main_mem_r          <= 1'b0;
      sel_sys_bus_r           <= 1'b0;
      sel_boot_r              <= 1'b0;
      sel_sram_r              <= 1'b0;
      sel_local_io_r          <= 1'b0;
      sel_iack_r              <= 1'b0;
      sel_bridge_prescaler_r  <= 1'b0;
      dup_logic_enable_r      <= 1'b0;
      abort_irq_r             <= 1'b0;
      comp_read_data_r        <= 32'h0000_0000;
      ack_none_r              <= 1'b0;
      transfer_error_r        <= 1'b0;
      sys_in_valid_r          <= 1'b0;
      sys_in_local_addr_r     <= 32'h0000_0000;
      boot_dev_addr_r         <= 22'h00_0000;
    end else begin
      state_r <= state_nxt;
      flash_write_protect_out <= flash_wp_ctl;
      boot_config_select_out  <= boot_config_ctl;
      // Half select in shared mode only.
      flash_half_select_out   <= boot_config_ctl ? 1'b0 : flash_half_ctl;
      supply_status_r         <= supply_status_input;
      if (clear_boot_alias)
        boot_alias_bit <= 1'b0;
      dup_logic_enable_r <= ~bridge_present;
      abort_irq_r        <= abort_switch & abort_int_enable;
      transfer_error_r   <= (state_nxt == ST_TERM);
      if (cycle_start && state_r == ST_IDLE) begin
        sel_main_mem_r   <= hit_main;
        sel_sys_bus_r    <= hit_sys;
        sel_boot_r       <= hit_boot & ~bridge_boot_decode_en;
        sel_sram_r       <= hit_sram & ~bridge_boot_decode_en;
        sel_local_io_r   <= hit_io;
        sel_iack_r       <= iack_type;
        sel_bridge_prescaler_r <= normal_type && ~sys_bus_enable &&
                                  addr == `LBMD_ADDR_BRG_PRESC;
        undecoded_r      <= hit_undec;
        ack_none_r       <= hit_undec;
        comp_read_data_r <= rd_nxt;
        boot_dev_addr_r  <= {(boot_config_ctl ? addr[21] : flash_half_ctl),
                             addr[20:0]};
      end else if (state_nxt == ST_IDLE) begin
        sel_main_mem_r         <= 1'b0;
        sel_sys_bus_r          <= 1'b0;
        sel_boot_r             <= 1'b0;
        sel_sram_r             <= 1'b0;
        sel_local_io_r         <= 1'b0;
        sel_iack_r             <= 1'b0;
        sel_bridge_prescaler_r <= 1'b0;
        undecoded_r            <= 1'b0;
        ack_none_r             <= 1'b0;
      end
      sys_in_valid_r <= sys_in_valid;
      sys_in_local_addr_r <= sys_in_addr + XLATE_BASE;
    end
  end
endmodule // lbmd_decoder

// >>> test/lbmd_chk.sv
`timescale 1ns/1ps
module lbmd_chk (
  input wire        clk,
  input wire        arst_n,
  input wire        cycle_start,
  input wire [31:0] addr,
  input wire [1:0]  transfer_type_code,
  input wire        flash_wp_ctl,
  input wire        bridge_present,
  input wire        clear_boot_alias,
  input wire [7:0]  general_input_pins,
  input wire        flash_write_protect_out,
  input wire        boot_alias_bit,
  input wire        sel_main_mem_r,
  input wire        sel_sys_bus_r,
  input wire        sel_boot_r,
  input wire        sel_sram_r,
  input wire        sel_local_io_r,
  input wire        sel_iack_r,
  input wire        dup_logic_enable_r,
  input wire [31:0] comp_read_data_r,
  input wire        ack_none_r
);
  wire [5:0] sels = {sel_main_mem_r, sel_sys_bus_r, sel_boot_r, sel_sram_r,
                     sel_local_io_r, sel_iack_r};
  // A start only counts when no earlier cycle is still open.
  wire       go   = cycle_start && sels == 6'h00 && !ack_none_r;
  default clocking cb @(posedge clk); endclocking
  default disable iff (!arst_n);
  property p_wp; $past(arst_n) |->
    flash_write_protect_out == $past(flash_wp_ctl); endproperty
  a_wp: assert property (p_wp) else $error("bad wp");
  property p_dup; $past(arst_n) |->
    dup_logic_enable_r == !$past(bridge_present); endproperty
  a_dup: assert property (p_dup) else $error("bad dup");
  property p_alias; !boot_alias_bit |=> !boot_alias_bit; endproperty
  a_alias: assert property (p_alias) else $error("alias set");
  property p_clr; clear_boot_alias |=> !boot_alias_bit; endproperty
  a_clr: assert property (p_clr) else $error("alias kept");
  property p_iack; go && transfer_type_code == 2'h3 |=> sels == 6'h01;
  endproperty
  a_iack: assert property (p_iack) else $error("bad iack");
  property p_io; go && transfer_type_code != 2'h3 &&
    addr >= 32'hfff0_0000 && addr <= 32'hfffe_ffff |=> sel_local_io_r;
  endproperty
  a_io: assert property (p_io) else $error("no io sel");
  property p_one; $onehot0(sels); endproperty
  a_one: assert property (p_one) else $error("many sels");
  property p_gpi; go && addr == 32'hfff4_202c |=>
    comp_read_data_r[23:16] == $past(general_input_pins); endproperty
  a_gpi: assert property (p_gpi) else $error("bad gpi");
endmodule // lbmd_chk

bind lbmd_decoder lbmd_chk u_chk (.*);

// >>> test/lbmd_target.sv
`timescale 1ns/1ps
module lbmd_target (
  input  wire       clk,
  input  wire       busy,
  input  wire [3:0] lat,
  output reg        cycle_end = 1'b0
);
  reg [3:0] wait_r = 4'h0;
  // A slow target holds each cycle open for lat extra cycles.
  always @(negedge clk) begin
    cycle_end <= busy && !cycle_end && wait_r == lat;
    wait_r <= (busy && !cycle_end) ? wait_r + 4'h1 : 4'h0;
  end
endmodule // lbmd_target

// >>> test/lbmd_decoder_bench.sv
`timescale 1ns/1ps
module lbmd_decoder_bench;
  reg        clk, arst_n, cycle_start, sys_bus_enable, bridge_present;
  reg        bridge_boot_decode_en, bus_timer_enable, clear_boot_alias;
  reg        flash_wp_ctl, flash_half_ctl, boot_config_ctl, sys_in_valid;
  reg        supply_status_input, abort_switch, abort_int_enable;
  reg [31:0] addr, reset_wdog_bits, sys_in_addr;
  reg [7:0]  general_input_pins;
  reg [6:0]  smask;
  reg [3:0]  lat;
  reg [1:0]  transfer_type_code, bus_timer_sel;
  wire       flash_write_protect_out, flash_half_select_out, cycle_end;
  wire       boot_config_select_out, supply_status_r, boot_alias_bit;
  wire       sel_main_mem_r, sel_sys_bus_r, sel_boot_r, sel_sram_r;
  wire       sel_local_io_r, sel_iack_r, sel_bridge_prescaler_r;
  wire       dup_logic_enable_r, abort_irq_r, ack_none_r, sys_in_valid_r;
  wire       transfer_error_r;
  wire [31:0] comp_read_data_r, sys_in_local_addr_r;
  wire [21:0] boot_dev_addr_r;
  wire [6:0] sels = {sel_main_mem_r, sel_sys_bus_r, sel_boot_r, sel_sram_r,
                     sel_local_io_r, sel_iack_r, sel_bridge_prescaler_r};
  integer    bad_count, comparisons, n;

  lbmd_decoder uut (.*);
  lbmd_target u_tgt (.clk(clk), .busy(|sels), .lat(lat),
                     .cycle_end(cycle_end));

  initial begin
    clk = 1'b0;
    forever #2.5 clk = ~clk;
  end

  initial begin
    #40000;
    bad_count = bad_count + 1;
    summarize;
  end

  task chk(input [63:0] nm, input [31:0] e, input [31:0] g);
    comparisons = comparisons + 1;
    if (g !== e) begin
      bad_count = bad_count + 1;
      $display("FAIL %0s exp %h got %h", nm, e, g);
    end
  endtask

  // One local bus cycle; the partner ends it lat cycles after a select shows.
  task run(input [31:0] a, input [1:0] t, input [6:0] es, input [31:0] m,
           input [31:0] ed);
    @(negedge clk);
    cycle_start = 1'b1;
    addr = a;
    transfer_type_code = t;
    @(negedge clk);
    cycle_start = 1'b0;
    chk("sels", es & smask, sels & smask);
    chk("rdata", ed, comp_read_data_r & m);
    for (n = 0; n < 20 && |sels; n = n + 1)
      @(negedge clk);
  endtask

  task summarize;
    if (bad_count == 0 && comparisons > 0)
      $display("ALL CHECKS OK");
    else
      $display("CHECKS NOT OK");
    $finish;
  endtask

  initial begin
    {cycle_start, bus_timer_enable, clear_boot_alias, boot_config_ctl,
     bus_timer_sel, addr, transfer_type_code, sys_in_addr} = 0;
    {flash_wp_ctl, flash_half_ctl, supply_status_input, bridge_present,
     sys_in_valid, abort_switch, abort_int_enable, sys_bus_enable} = 8'hff;
    bridge_boot_decode_en = 1'b0;
    general_input_pins = 8'ha5;
    reset_wdog_bits = 32'h1f7b_3f00;
    sys_in_addr = 32'h0012_3400;
    {bad_count, comparisons} = 0;
    lat = 4'h0;
    smask = 7'h7f;
    arst_n = 1'b0;
    repeat (12) @(negedge clk);
    arst_n = 1'b1;
    repeat (2) @(negedge clk);
    chk("alias", 32'h1, boot_alias_bit);
    chk("wp", 32'h1, flash_write_protect_out);
    chk("half", 32'h1, flash_half_select_out);
    chk("supply", 32'h1, supply_status_r);
    chk("dup", 32'h0, dup_logic_enable_r);
    chk("irq", 32'h1, abort_irq_r);
    chk("inv", 32'h1, sys_in_valid_r);
    chk("xlat", 32'h0012_3400, sys_in_local_addr_r);
    boot_config_ctl = 1'b1;
    bridge_present = 1'b0;
    sys_in_valid = 1'b0;
    repeat (2) @(negedge clk);
    chk("cfg", 32'h1, boot_config_select_out);
    chk("half", 32'h0, flash_half_select_out);
    chk("dup", 32'h1, dup_logic_enable_r);
    chk("inv", 32'h0, sys_in_valid_r);
    run(32'h0000_1000, 2'h0, 7'h10, 32'h0, 32'h0);
    clear_boot_alias = 1'b1;
    @(negedge clk);
    clear_boot_alias = 1'b0;
    chk("alias", 32'h0, boot_alias_bit);
    run(32'hff80_1000, 2'h0, 7'h10, 32'h0, 32'h0);
    chk("bdev", 32'h0000_1000, boot_dev_addr_r);
    boot_config_ctl = 1'b0;
    run(32'hff80_1000, 2'h0, 7'h10, 32'h0, 32'h0);
    chk("bdev", 32'h0020_1000, boot_dev_addr_r);
    run(32'h0000_1000, 2'h1, 7'h40, 32'h0, 32'h0);
    lat = 4'h3;
    run(32'h1000_0000, 2'h2, 7'h20, 32'h0, 32'h0);
    run(32'hfffe_ffff, 2'h2, 7'h04, 32'h0, 32'h0);
    run(32'hfff0_0000, 2'h3, 7'h02, 32'h0, 32'h0);
    run(32'hfff4_202c, 2'h0, 7'h04, 32'h00ff_0000, 32'h00a5_0000);
    run(32'hfff4_2043, 2'h0, 7'h04, 32'h0000_0003, 32'h0000_0003);
    run(32'hfff4_2044, 2'h0, 7'h04, 32'hffff_ffff, 32'h1f7b_3f00);
    run(32'hfff4_0088, 2'h0, 7'h04, 32'hffff_ffff, 32'h0);
    run(32'hfff4_0064, 2'h0, 7'h04, 32'h0, 32'h0);
    sys_bus_enable = 1'b0;
    smask = 7'h01;
    run(32'hfff4_0064, 2'h0, 7'h01, 32'h0, 32'h0);
    smask = 7'h7f;
    bus_timer_enable = 1'b1;
    run(32'hffc0_0000, 2'h0, 7'h00, 32'h0, 32'h0);
    chk("nack", 32'h1, ack_none_r);
    for (n = 0; n < 1700 && transfer_error_r !== 1'b1; n = n + 1)
      @(negedge clk);
    chk("tea", 32'h1, transfer_error_r);
    summarize;
  end
endmodule // lbmd_decoder_bench
